// [atrp_asserts.sv]
// checker of the sequencer's start latency and byte stream timing
// assumes: bound to atrp_top, single clock domain
`timescale 1ns/1ps
module atrp_asserts #(
	parameter [12:0] GT_CYCLES = 13'd20
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire tx_valid,
	input wire [7:0] tx_data
);
	// ----
	// start detection and byte spacing
	// ----
	logic aw_reg, armed_reg;
	logic [12:0] gap_reg;
	logic [5:0] cnt_reg;
	wire go = aw_reg && hwdata[0];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aw_reg <= 1'b0;
			armed_reg <= 1'b0;
			gap_reg <= 13'h1fff;
			cnt_reg <= 6'h00;
		end else begin
			aw_reg <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
			armed_reg <= armed_reg || go;
			gap_reg <= tx_valid ? 13'h0000 : gap_reg + 13'(gap_reg != 13'h1fff);
			cnt_reg <= go ? 6'h00 : cnt_reg + 6'(tx_valid);
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence start_s; go; endsequence
	sequence pulse_s; tx_valid ##1 !tx_valid; endsequence
	start_lat_a: assert property (start_s |-> ##[2:4] tx_valid)
		else $error("no byte after start");
	start_gap_a: assert property (start_s |=> !tx_valid)
		else $error("byte too soon after start");
	pulse_one_a: assert property (tx_valid |-> pulse_s)
		else $error("byte strobe too long");
	guard_gap_a: assert property (tx_valid && cnt_reg != 6'h00 |-> gap_reg == GT_CYCLES - 13'd1)
		else $error("guard time wrong");
	len_cap_a: assert property (cnt_reg <= 6'd32)
		else $error("too many bytes");
	no_spur_a: assert property (tx_valid |-> armed_reg)
		else $error("byte without start");
	data_hold_a: assert property (!tx_valid |-> $stable(tx_data))
		else $error("byte changed without strobe");
	rst_idle_a: assert property ($rose(hresetn) |-> !tx_valid)
		else $error("byte right after reset");
endmodule // atrp_asserts
bind atrp_top atrp_asserts #(.GT_CYCLES(GT_CYCLES)) u_chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .tx_valid, .tx_data);

// [atrp_consts.vh]
// constants of the answer-to-reset sequence builder (card side)
// assumes: included by every design file of the block, hclk is the card clock
//
// Contract
// - format byte: indicator high, history count low
// - structural byte: next indicator high, type low
// - indicator bits order TA TB TC TD
// - types ascending, never type 15 first
// - exactly K historical bytes follow, K<=15
// - check byte unless only type 0; xor zero
// - card avoids deprecated bytes; reader ignores them (sequencer still sends TB1/TB2 and sets the TBDEP status bit)
// - card sends with plain 12 etu guard
// - sequence after initial character at most 32 bytes
`ifndef ATRP_CONSTS_VH
`define ATRP_CONSTS_VH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define ATRP_OFF_CTRL 8'h00
`define ATRP_OFF_STAT 8'h04
`define ATRP_OFF_TCK 8'h08
`define ATRP_OFF_BUF 8'h40
`define ATRP_OFF_BUF_END 8'hc0
`define ATRP_CTRL_START 0
`define ATRP_ST_BUSY 0
`define ATRP_ST_DONE 1
`define ATRP_ST_ORDER 2
`define ATRP_ST_T15 3
`define ATRP_ST_LEN 4
`define ATRP_ST_TBDEP 5
`define ATRP_ST_TCK 6
`define ATRP_ST_CNT_LO 8

// ---------------------------------------------------------------
// sequence structure
// ---------------------------------------------------------------
`define ATRP_MAX_LEN 6'h20
`define ATRP_AW 5
`define ATRP_TYPE_GLOBAL 4'hf
`define ATRP_TYPE_ZERO 4'h0
`define ATRP_IND_TD 2'h3
`define ATRP_IND_TB 2'h1
`define ATRP_GT_ETU 12
`define ATRP_FD 372
`define ATRP_START_WAIT 13'h0002

`endif

// [atrp_mem.v]
// 32-byte image of the sequence to send, written by software
// assumes: one write port, one read port, read data registered
`timescale 1ns/1ps
`include "atrp_consts.vh"
module atrp_mem (
	input wire hclk,
	input wire we,
	input wire [`ATRP_AW-1:0] waddr,
	input wire [7:0] wdata,
	input wire [`ATRP_AW-1:0] raddr,
	output reg [7:0] rdata
);
	reg [7:0] mem [0:(1<<`ATRP_AW)-1];

	always @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // atrp_mem

// [atrp_reader.sv]
// reader model: collects card bytes and marks the end of the answer
// assumes: fed by the sequencer's byte strobe
`timescale 1ns/1ps
module atrp_reader #(
	parameter int GT = 20
) (
	input wire hclk,
	input wire hresetn,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output logic ended
);
	logic [7:0] rx_q[$];
	int idle;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle <= 0;
			ended <= 1'b0;
		end else if (tx_valid) begin
			rx_q.push_back(tx_data);
			idle <= 0;
			ended <= 1'b0;
		end else begin
			idle <= idle + 1;
			ended <= idle >= GT - 1;
		end
	end
	// first offered type and running xor of what was received
	task automatic decode(output logic [3:0] t1, output logic [7:0] sum);
		int p;
		logic [3:0] y;
		sum = 8'h00;
		foreach (rx_q[i]) sum ^= rx_q[i];
		t1 = 4'h0;
		if (rx_q.size() == 0) return;
		y = rx_q[0][7:4];
		p = 1 + int'(y[0]) + int'(y[1]) + int'(y[2]);
		if (y[3] && p < rx_q.size()) t1 = rx_q[p][3:0];
	endtask
endmodule // atrp_reader

// [atrp_top.v]
// card-side answer-to-reset byte sequencer with AHB-Lite registers
// assumes: software loads the image from the format byte on, then starts;
// bytes go out on tx_data with a one-cycle tx_valid, one per guard time
`timescale 1ns/1ps
`include "atrp_consts.vh"
module atrp_top #(
	parameter [12:0] GT_CYCLES = `ATRP_GT_ETU * `ATRP_FD
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	output reg [7:0] tx_data,
	output reg tx_valid
);
	localparam S_IDLE = 1'b0;
	localparam S_RUN = 1'b1;
	localparam P_T0 = 3'd0;
	localparam P_IF = 3'd1;
	localparam P_HIST = 3'd2;
	localparam P_TCK = 3'd3;
	localparam P_END = 3'd4;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// lowest pending indicator bit: TA, TB, TC, then TD
	function [1:0] first_ind;
		input [3:0] y;
		begin
			if (y[0]) first_ind = 2'd0;
			else if (y[1]) first_ind = 2'd1;
			else if (y[2]) first_ind = 2'd2;
			else first_ind = 2'd3;
		end
	endfunction

	// what follows once the pending indicator and history are known
	function [2:0] next_phase;
		input [3:0] y;
		input [3:0] k;
		input tck;
		begin
			if (y != 4'h0) next_phase = P_IF;
			else if (k != 4'h0) next_phase = P_HIST;
			else if (tck) next_phase = P_TCK;
			else next_phase = P_END;
		end
	endfunction

	// ---------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ---------------------------------------------------------------
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	wire acc = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire wr_now = wr_pend_reg;
	// image window spans 32 words; index taken relative to its base
	wire [7:0] buf_off = wr_addr_reg - `ATRP_OFF_BUF;
	wire buf_we = wr_now & (wr_addr_reg >= `ATRP_OFF_BUF) & (wr_addr_reg < `ATRP_OFF_BUF_END);
	wire start_wr = wr_now & (wr_addr_reg == `ATRP_OFF_CTRL) & hwdata[`ATRP_CTRL_START];

	// ---------------------------------------------------------------
	// sequencer state
	// ---------------------------------------------------------------
	reg state_reg;
	reg [2:0] phase_reg;
	reg [12:0] cnt_reg;
	reg [3:0] y_reg;
	reg [3:0] k_reg;
	reg [3:0] last_t_reg;
	reg td_seen_reg;
	reg [3:0] grp_reg;
	reg tck_need_reg;
	reg [7:0] xor_reg;
	reg [5:0] sent_reg;
	reg done_reg, order_err_reg, t15_err_reg, len_err_reg, tbdep_reg, tck_sent_reg;
	wire [7:0] mem_rd;

	atrp_mem u_mem (
		.hclk(hclk),
		.we(buf_we),
		.waddr(buf_off[`ATRP_AW+1:2]),
		.wdata(hwdata[7:0]),
		.raddr(sent_reg[`ATRP_AW-1:0]),
		.rdata(mem_rd)
	);

	wire fire = (state_reg == S_RUN) & (cnt_reg == 13'h0000);
	wire [7:0] cur_byte = (phase_reg == P_TCK) ? xor_reg : mem_rd;
	wire [1:0] ind = first_ind(y_reg);
	wire [3:0] cur_t = cur_byte[3:0];
	wire is_td = (phase_reg == P_IF) & (ind == `ATRP_IND_TD);
	wire bad_t15 = is_td & ~td_seen_reg & (cur_t == `ATRP_TYPE_GLOBAL);
	wire bad_order = is_td & td_seen_reg & (cur_t < last_t_reg);
	wire too_long = (sent_reg == `ATRP_MAX_LEN);

	reg [2:0] phase_next;
	reg [3:0] y_next, k_next;
	reg tck_next;
	always @* begin
		y_next = y_reg;
		k_next = k_reg;
		tck_next = tck_need_reg;
		phase_next = P_END;
		case (phase_reg)
			P_T0: begin
				y_next = cur_byte[7:4];
				k_next = cur_byte[3:0];
				phase_next = next_phase(y_next, k_next, tck_next);
			end
			P_IF: begin
				if (ind == `ATRP_IND_TD) begin
					y_next = cur_byte[7:4];
					tck_next = tck_need_reg | (cur_t != `ATRP_TYPE_ZERO);
				end else begin
					y_next = y_reg & ~(4'h1 << ind);
				end
				phase_next = next_phase(y_next, k_next, tck_next);
			end
			P_HIST: begin
				k_next = k_reg - 4'h1;
				phase_next = next_phase(4'h0, k_next, tck_next);
			end
			default: begin
				phase_next = P_END;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= S_IDLE;
			phase_reg <= P_T0;
			cnt_reg <= 13'h0000;
			y_reg <= 4'h0;
			k_reg <= 4'h0;
			last_t_reg <= 4'h0;
			td_seen_reg <= 1'b0;
			grp_reg <= 4'h0;
			tck_need_reg <= 1'b0;
			xor_reg <= 8'h00;
			sent_reg <= 6'h00;
			done_reg <= 1'b0;
			order_err_reg <= 1'b0;
			t15_err_reg <= 1'b0;
			len_err_reg <= 1'b0;
			tbdep_reg <= 1'b0;
			tck_sent_reg <= 1'b0;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
		end else begin
			tx_valid <= 1'b0;
			if (state_reg == S_IDLE) begin
				if (start_wr) begin
					state_reg <= S_RUN;
					phase_reg <= P_T0;
					cnt_reg <= `ATRP_START_WAIT;
					y_reg <= 4'h0;
					k_reg <= 4'h0;
					last_t_reg <= 4'h0;
					td_seen_reg <= 1'b0;
					grp_reg <= 4'h1;
					tck_need_reg <= 1'b0;
					xor_reg <= 8'h00;
					sent_reg <= 6'h00;
					done_reg <= 1'b0;
					order_err_reg <= 1'b0;
					t15_err_reg <= 1'b0;
					len_err_reg <= 1'b0;
					tbdep_reg <= 1'b0;
					tck_sent_reg <= 1'b0;
				end
			end else if (!fire) begin
				cnt_reg <= cnt_reg - 13'h0001;
			end else if (too_long) begin
				len_err_reg <= 1'b1;
				state_reg <= S_IDLE;
			end else if (bad_t15 | bad_order) begin
				t15_err_reg <= bad_t15;
				order_err_reg <= bad_order;
				state_reg <= S_IDLE;
			end else begin
				tx_data <= cur_byte;
				tx_valid <= 1'b1;
				xor_reg <= xor_reg ^ cur_byte;
				sent_reg <= sent_reg + 6'h01;
				cnt_reg <= GT_CYCLES - 13'h0001;
				y_reg <= y_next;
				k_reg <= k_next;
				tck_need_reg <= tck_next;
				phase_reg <= phase_next;
				if (phase_reg == P_TCK) begin
					tck_sent_reg <= 1'b1;
				end
				if (is_td) begin
					td_seen_reg <= 1'b1;
					last_t_reg <= cur_t;
					grp_reg <= grp_reg + 4'h1;
				end
				if ((phase_reg == P_IF) & (ind == `ATRP_IND_TB) & (grp_reg < 4'h3)) begin
					tbdep_reg <= 1'b1;
				end
				if (phase_next == P_END) begin
					state_reg <= S_IDLE;
					done_reg <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// bus registers
	// ---------------------------------------------------------------
	wire [31:0] stat_word = {18'h00000, sent_reg, 1'b0, tck_sent_reg, tbdep_reg,
		len_err_reg, t15_err_reg, order_err_reg, done_reg, state_reg};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			wr_pend_reg <= acc & hwrite;
			if (acc) begin
				wr_addr_reg <= haddr[7:0];
			end
			if (acc & ~hwrite) begin
				if (haddr[7:0] == `ATRP_OFF_STAT) begin
					hrdata <= stat_word;
				end else if (haddr[7:0] == `ATRP_OFF_TCK) begin
					hrdata <= {24'h000000, xor_reg};
				end else begin
					hrdata <= 32'h00000000;
				end
			end
		end
	end
endmodule // atrp_top

// [test_atr_interface_byte_parser.sv]
// self-checking bench: random images sent and compared with a model
// assumes: checker bound to atrp_top, reader model alongside
`timescale 1ns/1ps
`include "atrp_consts.vh"
module test_atr_interface_byte_parser;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, seed = 32'hd699baa4;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, tx_valid, ended;
	logic [7:0] tx_data, xr, rsum;
	logic [3:0] t1x, rt1;
	logic [7:0] img[32];
	logic [7:0] exp_q[$];
	logic [6:0] st;
	logic [79:0] tab[7] = '{80'h3, 80'h00f2_0411, 80'h0080_0181_0200, 80'h0080_010f,
		80'h00ff_04f0_08f1_0cfe_100f, 80'h0081_0100, 80'h0080_0180_020f};
	int n_errors = 0, checks = 0;
	wire hready = hreadyout;
	atrp_top #(.GT_CYCLES(13'd20)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tx_data, .tx_valid);
	atrp_reader #(.GT(20)) u_rd (.hclk, .hresetn, .tx_data, .tx_valid, .ended);
	initial forever #50 hclk = ~hclk;
	// ----
	// tasks
	// ----
	task summarize();
		$display("n_errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(logic [31:0] got, logic [31:0] want);
		checks++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task ahb(bit w, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (!hready);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hready);
		r = hrdata;
	endtask
	function logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function bit put(logic [7:0] b);
		if (exp_q.size() == 32) begin
			st[4] = 1'b1;
			return 1'b0;
		end
		exp_q.push_back(b);
		xr ^= b;
		return 1'b1;
	endfunction
	task automatic model();
		int p = 1, g = 1, last = 0;
		logic [3:0] y, ny;
		logic ok, ck = 1'b0;
		exp_q = {};
		t1x = 4'h0;
		xr = 8'h00;
		st = 7'h0;
		y = img[0][7:4];
		ok = put(img[0]);
		while (ok && y != 4'h0) begin
			ny = 4'h0;
			for (int i = 0; i < 4; i++) if (ok && y[i]) begin
				if (i == 3 && exp_q.size() < 32 && g == 1 && img[p][3:0] == 4'hf)
					st[3] = 1'b1;
				if (i == 3 && exp_q.size() < 32 && img[p][3:0] < last) st[2] = 1'b1;
				ok = !st[3] && !st[2] && put(img[p]);
				if (ok && i == 1 && g < 3) st[5] = 1'b1;
				if (ok && i == 3) begin
					ny = img[p][7:4];
					if (g == 1) t1x = img[p][3:0];
					last = img[p][3:0];
					ck |= last != 0;
					g++;
				end
				p++;
			end
			y = ny;
		end
		for (int k = 0; k < img[0][3:0]; k++) if (ok) ok = put(img[p + k]);
		if (ok && ck) st[6] = put(xr);
	endtask
	task automatic run(int s);
		int w = 0;
		for (int n = 0; n < 32; n++) begin
			seed = lfsr(seed);
			img[n] = seed[7:0];
		end
		for (int i = 0; i < 5; i++) if (tab[s][16*i +: 16] != 0)
			img[tab[s][16*i+8 +: 8]] = tab[s][16*i +: 8];
		for (int n = 0; n < 32; n++) ahb(1'b1, 8'(64 + 4 * n), {24'h0, img[n]});
		u_rd.rx_q.delete();
		ahb(1'b1, `ATRP_OFF_CTRL, 32'h1);
		repeat (8) @(posedge hclk);
		while (!ended && w < 2000) begin
			@(posedge hclk);
			w++;
		end
		chk(ended, 1'b1);
		model();
		u_rd.decode(rt1, rsum);
		chk(rt1, t1x);
		chk(rsum, xr);
		ahb(1'b0, `ATRP_OFF_STAT, 32'h0);
		chk(r[6:2], st[6:2]);
		chk(r[1:0], {!(st[2] | st[3] | st[4]), 1'b0});
		chk(r[13:8], exp_q.size());
		ahb(1'b0, `ATRP_OFF_TCK, 32'h0);
		chk(r, {24'h0, xr});
		chk(u_rd.rx_q.size(), exp_q.size());
		foreach (exp_q[i]) chk(u_rd.rx_q[i], exp_q[i]);
	endtask
	// ----
	// main sequence and watchdog
	// ----
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int s = 0; s < 7; s++) run(s);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(r, 32'h0);
		summarize();
	end
	initial begin
		#2000000;
		n_errors++;
		summarize();
	end
endmodule // test_atr_interface_byte_parser
